// ===== src/adcr_control_bank.v
// Converter control register bank with derived configuration outputs
`include "adcr_defines.vh"
module adcr_control_bank (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        zero_cross_pin,
   input  wire        ramp_tick,
   output reg  [15:0] reg_rdata,
   output reg         reg_rvalid,
   output reg         deemphasis_enable,
   output reg         interface_master_select,
   output reg         frame_clock_invert,
   output reg         dsp_mode_b,
   output reg         sample_on_falling,
   output reg         bit_clock_drive_invert,
   output reg  [5:0]  sample_bits,
   output reg  [1:0]  serial_format_select,
   output reg  [1:0]  output_mix_select,
   output reg  [7:0]  bit_clock_ratio,
   output reg         bit_clock_from_mclk,
   output reg         bit_clock_reserved,
   output reg  [2:0]  master_clock_ratio,
   output reg         ratio_auto_detect,
   output reg  [10:0] mclk_per_frame,
   output reg         zero_cross_enable,
   output reg         right_channel_mute,
   output reg         left_channel_mute,
   output reg         volume_rise_ramp,
   output reg         volume_fall_ramp,
   output reg  [11:0] silence_count,
   output reg  [8:0]  left_volume_now,
   output reg  [8:0]  right_volume_now
);
   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg  [15:0] if1;
   reg  [15:0] if2;
   reg  [15:0] mutev;
   reg  [15:0] gain_l;
   reg  [15:0] gain_r;
   reg  [15:0] silence;
   reg  [8:0]  target_l;
   reg  [8:0]  target_r;
   reg         zc_meta;
   reg         zc_sync;
   wire [17:0] levels;
   wire [17:0] targets;
   wire        apply_now;
   reg  [15:0] next_rdata;

   assign apply_now = reg_wr & reg_wdata[`ADCR_BIT_APPLY] &
                      (reg_addr == `ADCR_ADDR_GAINL || reg_addr == `ADCR_ADDR_GAINR);
   assign targets = {target_r, target_l};

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         if1      <= `ADCR_RST_IF1;
         if2      <= `ADCR_RST_IF2;
         mutev    <= `ADCR_RST_MUTE;
         gain_l   <= `ADCR_RST_GAIN;
         gain_r   <= `ADCR_RST_GAIN;
         silence  <= `ADCR_RST_SILENCE;
         target_l <= `ADCR_RST_LEVEL;
         target_r <= `ADCR_RST_LEVEL;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `ADCR_ADDR_IF1:     if1     <= reg_wdata & `ADCR_MASK_IF1;
               `ADCR_ADDR_IF2:     if2     <= reg_wdata & `ADCR_MASK_IF2;
               `ADCR_ADDR_MUTE:    mutev   <= reg_wdata & `ADCR_MASK_MUTE;
               `ADCR_ADDR_GAINL:   gain_l  <= reg_wdata & `ADCR_MASK_GAIN;
               `ADCR_ADDR_GAINR:   gain_r  <= reg_wdata & `ADCR_MASK_GAIN;
               `ADCR_ADDR_SILENCE: silence <= reg_wdata & `ADCR_MASK_SILENCE;
               default: ;
            endcase
         end
         // Pending pair applied together, including the value of this write
         if (apply_now) begin
            target_l <= (reg_addr == `ADCR_ADDR_GAINL) ? reg_wdata[8:0] : gain_l[8:0];
            target_r <= (reg_addr == `ADCR_ADDR_GAINR) ? reg_wdata[8:0] : gain_r[8:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always @* begin
      case (reg_addr)
         `ADCR_ADDR_IF1:     next_rdata = if1;
         `ADCR_ADDR_IF2:     next_rdata = if2;
         `ADCR_ADDR_MUTE:    next_rdata = mutev;
         `ADCR_ADDR_GAINL:   next_rdata = gain_l;
         `ADCR_ADDR_GAINR:   next_rdata = gain_r;
         `ADCR_ADDR_SILENCE: next_rdata = silence;
         default:            next_rdata = 16'h0000;
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Zero crossing input synchroniser
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         zc_meta <= 1'b0;
         zc_sync <= 1'b0;
      end else begin
         zc_meta <= zero_cross_pin;
         zc_sync <= zc_meta;
      end
   end

   // ----------------------------------------------------------------
   // Volume trackers
   // ----------------------------------------------------------------
   // Channel 0 is left, channel 1 is right
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         adcr_volume_channel u_chan (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .target     (targets[9*ch +: 9]),
            .rise_ramp  (mutev[`ADCR_BIT_RISE]),
            .fall_ramp  (mutev[`ADCR_BIT_FALL]),
            .zc_enable  (mutev[`ADCR_BIT_ZC]),
            .zero_cross (zc_sync),
            .ramp_tick  (ramp_tick),
            .level      (levels[9*ch +: 9])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Decoded configuration outputs
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         deemphasis_enable       <= 1'b0;
         interface_master_select <= 1'b0;
         frame_clock_invert      <= 1'b0;
         dsp_mode_b              <= 1'b0;
         sample_on_falling       <= 1'b0;
         bit_clock_drive_invert  <= 1'b0;
         sample_bits             <= 6'h18;
         serial_format_select    <= 2'h2;
         output_mix_select       <= 2'h0;
         bit_clock_ratio         <= 8'h04;
         bit_clock_from_mclk     <= 1'b1;
         bit_clock_reserved      <= 1'b0;
         master_clock_ratio      <= 3'h0;
         ratio_auto_detect       <= 1'b1;
         mclk_per_frame          <= 11'h000;
         zero_cross_enable       <= 1'b0;
         right_channel_mute      <= 1'b0;
         left_channel_mute       <= 1'b0;
         volume_rise_ramp        <= 1'b0;
         volume_fall_ramp        <= 1'b1;
         silence_count           <= `ADCR_ZD_SHORT;
         left_volume_now         <= `ADCR_RST_LEVEL;
         right_volume_now        <= `ADCR_RST_LEVEL;
      end else begin
         deemphasis_enable       <= if1[`ADCR_BIT_DEEMP];
         interface_master_select <= if1[`ADCR_BIT_MASTER];
         serial_format_select    <= if1[`ADCR_FMT_HI:`ADCR_FMT_LO];
         if (if1[`ADCR_FMT_HI:`ADCR_FMT_LO] == `ADCR_FMT_DSP) begin
            frame_clock_invert <= 1'b0;
            dsp_mode_b         <= if1[`ADCR_BIT_LRPOL];
         end else begin
            frame_clock_invert <= if1[`ADCR_BIT_LRPOL];
            dsp_mode_b         <= 1'b0;
         end
         sample_on_falling      <= ~if1[`ADCR_BIT_MASTER] & if1[`ADCR_BIT_BCPOL];
         bit_clock_drive_invert <= if1[`ADCR_BIT_MASTER] & if1[`ADCR_BIT_BCPOL];
         case (if1[`ADCR_WL_HI:`ADCR_WL_LO])
            2'h0:    sample_bits <= 6'h10;
            2'h1:    sample_bits <= 6'h14;
            2'h2:    sample_bits <= 6'h18;
            default: sample_bits <= 6'h20;
         endcase
         output_mix_select <= if2[`ADCR_MIX_HI:`ADCR_MIX_LO];
         bit_clock_reserved <= 1'b0;
         case (if2[`ADCR_DIV_HI:`ADCR_DIV_LO])
            `ADCR_DIV_MCLK4: begin
               bit_clock_ratio     <= 8'h04;
               bit_clock_from_mclk <= 1'b1;
            end
            `ADCR_DIV_MCLK8: begin
               bit_clock_ratio     <= 8'h08;
               bit_clock_from_mclk <= 1'b1;
            end
            `ADCR_DIV_32FS: begin
               bit_clock_ratio     <= 8'h20;
               bit_clock_from_mclk <= 1'b0;
            end
            `ADCR_DIV_64FS: begin
               bit_clock_ratio     <= 8'h40;
               bit_clock_from_mclk <= 1'b0;
            end
            `ADCR_DIV_128FS: begin
               bit_clock_ratio     <= 8'h80;
               bit_clock_from_mclk <= 1'b0;
            end
            default: begin
               bit_clock_ratio     <= 8'h00;
               bit_clock_from_mclk <= 1'b0;
               bit_clock_reserved  <= 1'b1;
            end
         endcase
         master_clock_ratio <= if2[`ADCR_SR_HI:`ADCR_SR_LO];
         ratio_auto_detect  <= (if2[`ADCR_SR_HI:`ADCR_SR_LO] == 3'h0);
         case (if2[`ADCR_SR_HI:`ADCR_SR_LO])
            3'h1:    mclk_per_frame <= 11'h080;
            3'h2:    mclk_per_frame <= 11'h0C0;
            3'h3:    mclk_per_frame <= 11'h100;
            3'h4:    mclk_per_frame <= 11'h180;
            3'h5:    mclk_per_frame <= 11'h200;
            3'h6:    mclk_per_frame <= 11'h300;
            3'h7:    mclk_per_frame <= 11'h480;
            default: mclk_per_frame <= 11'h000;
         endcase
         zero_cross_enable  <= mutev[`ADCR_BIT_ZC];
         right_channel_mute <= mutev[`ADCR_BIT_MUTER];
         left_channel_mute  <= mutev[`ADCR_BIT_MUTEL];
         volume_rise_ramp   <= mutev[`ADCR_BIT_RISE];
         volume_fall_ramp   <= mutev[`ADCR_BIT_FALL];
         silence_count <= silence[`ADCR_BIT_ZDCNT] ? `ADCR_ZD_LONG : `ADCR_ZD_SHORT;
         left_volume_now  <= levels[8:0];
         right_volume_now <= levels[17:9];
      end
   end
endmodule

// ===== src/adcr_defines.vh
// Register map, field positions, reset values and timing counts of the converter control bank
// Contract
// - Bit 8 of interface control one enables de-emphasis when set; resets clear.
// - Bit 7 selects slave or master; master drives bit clock from 3-bit divider code.
// - Bit 6 inverts frame clock polarity for non-DSP formats.
// - In DSP format bit 6 picks mode A (second clock) or mode B (first).
// - Bit 5: slave picks sampling edge; master drives bit clock normal or inverted.
// - Bits 4:3 set word length 16, 20, 24 or 32; reset is 24.
// - Two-bit format field: right, left justified, I2S, DSP; reset is I2S.
// - Bits 7:6 route stereo, left to right, right to left, or average.
// - Zero-cross bit 4 makes volume changes wait for a zero crossing.
// - Bit 3 mutes right, bit 2 mutes left; both reset clear.
// - Bit 1 set ramps volume increases, clear steps them; resets clear.
// - Bit 0 set ramps volume decreases, clear steps them; resets set.
// - Volume write stores value; update bit 9 set applies both pending volumes together.
// - Volume code steps 0.25dB from -100dB; codes 1_11xx_xxxx clamp to +12dB.
// - Zero detect bit 0 selects count 1024 when clear, 2048 when set.
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADCR_ADDR_IF1        8'h03
`define ADCR_ADDR_IF2        8'h04
`define ADCR_ADDR_MUTE       8'h05
`define ADCR_ADDR_GAINL      8'h06
`define ADCR_ADDR_GAINR      8'h07
`define ADCR_ADDR_SILENCE    8'h08

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define ADCR_RST_IF1         16'h0012
`define ADCR_RST_IF2         16'h0000
`define ADCR_RST_MUTE        16'h0001
`define ADCR_RST_GAIN        16'h0190
`define ADCR_RST_LEVEL       9'h190
`define ADCR_RST_SILENCE     16'h0000
`define ADCR_MASK_IF1        16'h01FB
`define ADCR_MASK_IF2        16'h00FF
`define ADCR_MASK_MUTE       16'h001F
`define ADCR_MASK_GAIN       16'h01FF
`define ADCR_MASK_SILENCE    16'h0001

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCR_BIT_DEEMP       8
`define ADCR_BIT_MASTER      7
`define ADCR_BIT_LRPOL       6
`define ADCR_BIT_BCPOL       5
`define ADCR_WL_HI           4
`define ADCR_WL_LO           3
`define ADCR_FMT_HI          1
`define ADCR_FMT_LO          0
`define ADCR_MIX_HI          7
`define ADCR_MIX_LO          6
`define ADCR_DIV_HI          5
`define ADCR_DIV_LO          3
`define ADCR_SR_HI           2
`define ADCR_SR_LO           0
`define ADCR_BIT_ZC          4
`define ADCR_BIT_MUTER       3
`define ADCR_BIT_MUTEL       2
`define ADCR_BIT_RISE        1
`define ADCR_BIT_FALL        0
`define ADCR_BIT_APPLY       9
`define ADCR_BIT_ZDCNT       0

// ----------------------------------------------------------------
// Encodings and counts
// ----------------------------------------------------------------
`define ADCR_FMT_DSP         2'h3
`define ADCR_VOL_CLAMP       9'h1C0
`define ADCR_VOL_MAX         9'h1C0
`define ADCR_ZD_SHORT        12'h0400
`define ADCR_ZD_LONG         12'h0800
`define ADCR_DIV_MCLK4       3'h0
`define ADCR_DIV_MCLK8       3'h1
`define ADCR_DIV_32FS        3'h2
`define ADCR_DIV_64FS        3'h3
`define ADCR_DIV_128FS       3'h4

`endif

// ===== src/adcr_volume_channel.v
// One channel's volume tracker: step or ramp toward the target, optionally at zero crossing
`include "adcr_defines.vh"
module adcr_volume_channel (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire [8:0] target,
   input  wire       rise_ramp,
   input  wire       fall_ramp,
   input  wire       zc_enable,
   input  wire       zero_cross,
   input  wire       ramp_tick,
   output reg  [8:0] level
);
   wire [8:0] goal;
   wire       may_move;
   reg  [8:0] next_level;

   // Codes at and above the clamp all mean +12dB
   assign goal = (target >= `ADCR_VOL_CLAMP) ? `ADCR_VOL_MAX : target;
   assign may_move = ~zc_enable | zero_cross;

   always @* begin
      next_level = level;
      if (may_move) begin
         if (goal > level) begin
            if (rise_ramp) begin
               if (ramp_tick)
                  next_level = level + 9'h001;
            end else
               next_level = goal;
         end else if (goal < level) begin
            if (fall_ramp) begin
               if (ramp_tick)
                  next_level = level - 9'h001;
            end else
               next_level = goal;
         end
      end
   end

   always @(posedge clk) begin
      if (sys_rst)
         level <= `ADCR_RST_LEVEL;
      else
         level <= next_level;
   end
endmodule

// ===== test/adcr_control_bank_assertions.sv
// Port checker for the converter control bank
module adcr_control_bank_assertions (
   input wire        clk,
   input wire        sys_rst,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_rvalid,
   input wire        deemphasis_enable,
   input wire        interface_master_select,
   input wire        frame_clock_invert,
   input wire        dsp_mode_b,
   input wire        sample_on_falling,
   input wire        bit_clock_drive_invert,
   input wire [5:0]  sample_bits,
   input wire [1:0]  serial_format_select,
   input wire [1:0]  output_mix_select,
   input wire        bit_clock_from_mclk,
   input wire        bit_clock_reserved,
   input wire        ratio_auto_detect,
   input wire        zero_cross_enable,
   input wire        right_channel_mute,
   input wire        left_channel_mute,
   input wire        volume_rise_ramp,
   input wire        volume_fall_ramp,
   input wire [11:0] silence_count,
   input wire [8:0]  left_volume_now,
   input wire [8:0]  right_volume_now
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] wd1;
   logic [15:0] wd2;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Write data two cycles back, when decoded outputs have settled
   always @(posedge clk) begin
      wd1 <= reg_wdata;
      wd2 <= wd1;
   end
   property cfg(a, ok);
      reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a) |=> ok;
   endproperty
   read_answer_a: assert property ($past(reg_rd) == reg_rvalid)
      else $error("read valid not one cycle after read");
   deemph_role_a: assert property (cfg(8'h03,
      {deemphasis_enable, interface_master_select} == wd2[8:7]))
      else $error("de-emphasis or role wrong");
   frame_polarity_a: assert property (cfg(8'h03,
      {frame_clock_invert, dsp_mode_b} ==
      {wd2[6] && wd2[1:0] != 2'h3, wd2[6] && wd2[1:0] == 2'h3}))
      else $error("frame polarity or alignment wrong");
   bclk_edge_a: assert property (cfg(8'h03,
      {sample_on_falling, bit_clock_drive_invert} == {wd2[5] && !wd2[7], wd2[5] && wd2[7]}))
      else $error("bit clock polarity wrong");
   word_format_a: assert property (cfg(8'h03,
      serial_format_select == wd2[1:0] &&
      sample_bits == (wd2[4:3] == 2'h3 ? 6'h20 : 6'h10 + {wd2[4:3], 2'h0})))
      else $error("format or word length wrong");
   divider_flag_a: assert property (cfg(8'h04,
      {bit_clock_from_mclk, bit_clock_reserved} == {wd2[5:3] < 3'h2, wd2[5:3] > 3'h4}))
      else $error("divider decode wrong");
   mix_ratio_a: assert property (cfg(8'h04,
      output_mix_select == wd2[7:6] && ratio_auto_detect == (wd2[2:0] == 3'h0)))
      else $error("mix or ratio wrong");
   mute_ramp_a: assert property (cfg(8'h05,
      {zero_cross_enable, right_channel_mute, left_channel_mute, volume_rise_ramp,
      volume_fall_ramp} == wd2[4:0]))
      else $error("mute or ramp control wrong");
   silence_count_a: assert property (cfg(8'h08,
      silence_count == (wd2[0] ? 12'h0800 : 12'h0400))) else $error("silence count wrong");
   volume_clamp_a: assert property (left_volume_now <= 9'h1C0 && right_volume_now <= 9'h1C0)
      else $error("volume above clamp");
   cover property (reg_rvalid);
   cover property (dsp_mode_b);
   cover property (bit_clock_reserved);
endmodule

bind adcr_control_bank adcr_control_bank_assertions chk (.*);

// ===== test/adcr_control_bank_tb.sv
// Self-checking bench for the converter control bank
module adcr_control_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic zero_cross_pin = 1'h0;
   logic ramp_tick = 1'h0;
   logic reg_wr, reg_rd, reg_rvalid, deemphasis_enable, interface_master_select,
      frame_clock_invert, dsp_mode_b, sample_on_falling, bit_clock_drive_invert,
      bit_clock_from_mclk, bit_clock_reserved, ratio_auto_detect, zero_cross_enable,
      right_channel_mute, left_channel_mute, volume_rise_ramp, volume_fall_ramp, rd_ok;
   logic [1:0]  serial_format_select, output_mix_select;
   logic [2:0]  master_clock_ratio;
   logic [5:0]  sample_bits;
   logic [7:0]  reg_addr, bit_clock_ratio;
   logic [8:0]  left_volume_now, right_volume_now;
   logic [10:0] mclk_per_frame;
   logic [11:0] silence_count;
   logic [15:0] reg_wdata, reg_rdata, rd_val;
   logic [15:0] rv [6] = '{16'h0012, 16'h0000, 16'h0001, 16'h0190, 16'h0190, 16'h0000};
   logic [15:0] sb [4] = '{16'h0010, 16'h0014, 16'h0018, 16'h0020};
   logic [15:0] dv [8] = '{16'h0004, 16'h0008, 16'h0020, 16'h0040, 16'h0080, 16'h0000,
      16'h0000, 16'h0000};
   logic [15:0] mr [8] = '{16'h0000, 16'h0080, 16'h00C0, 16'h0100, 16'h0180, 16'h0200,
      16'h0300, 16'h0480};
   int miscompares = 0;
   int n_checks = 0;
   int i;
   always #25 clk = ~clk;
   adcr_control_bank dut (.*);
   adcr_host_model host (.*);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      host.get(a, rd_val, rd_ok);
      if (!rd_ok) begin
         miscompares++;
         give_verdict();
      end else begin
         check(rd_val, exp);
      end
   endtask
   task automatic wc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         ramp_tick <= 1'h1;
         @(posedge clk);
         ramp_tick <= 1'h0;
      end
      wc(4);
   endtask
   initial begin
      wc(2);
      sys_rst <= 1'h0;
      for (i = 0; i < 6; i++) begin
         rd_chk(8'h03 + i[7:0], rv[i]);
      end
      check(sample_bits, 16'h0018);
      check(silence_count, 16'h0400);
      check({deemphasis_enable, right_channel_mute, left_channel_mute, volume_rise_ramp,
         volume_fall_ramp}, 16'h0001);
      rd_chk(8'h04, 16'h0000);
      host.put(8'h03, 16'h01FB);
      rd_chk(8'h03, 16'h01FB);
      check({deemphasis_enable, interface_master_select, dsp_mode_b, frame_clock_invert,
         bit_clock_drive_invert, sample_on_falling}, 16'h003A);
      for (i = 0; i < 4; i++) begin
         host.put(8'h03, 16'h0060 | {11'h000, i[1:0], 1'h0, i[1:0]});
         wc(2);
         check(sample_bits, sb[i]);
         check(serial_format_select, i[1:0]);
         check({frame_clock_invert, dsp_mode_b, sample_on_falling},
            {i != 3, i == 3, 1'h1});
      end
      for (i = 0; i < 8; i++) begin
         host.put(8'h04, {8'h00, i[1:0], i[2:0], i[2:0]});
         wc(2);
         check(bit_clock_ratio, dv[i]);
         check({bit_clock_from_mclk, bit_clock_reserved, ratio_auto_detect},
            {i < 2, i > 4, i == 0});
         check(mclk_per_frame, mr[i]);
         check(master_clock_ratio, i[2:0]);
         check(output_mix_select, i[1:0]);
      end
      host.put(8'h05, 16'h001E);
      host.put(8'h08, 16'h0001);
      wc(2);
      check({zero_cross_enable, right_channel_mute, left_channel_mute, volume_rise_ramp,
         volume_fall_ramp}, 16'h001E);
      check(silence_count, 16'h0800);
      host.put(8'h05, 16'h0004);
      wc(2);
      check({right_channel_mute, left_channel_mute}, 16'h0001);
      host.put(8'h05, 16'h0000);
      host.put(8'h06, 16'h0100);
      wc(4);
      check(left_volume_now, 16'h0190);
      host.put(8'h07, 16'h0250);
      wc(4);
      check(left_volume_now, 16'h0100);
      check(right_volume_now, 16'h0050);
      rd_chk(8'h07, 16'h0050);
      host.put(8'h06, 16'h03FF);
      wc(4);
      check(left_volume_now, 16'h01C0);
      rd_chk(8'h06, 16'h01FF);
      host.put(8'h05, 16'h0003);
      host.put(8'h06, 16'h03BC);
      wc(4);
      check(left_volume_now, 16'h01C0);
      ticks(4);
      check(left_volume_now, 16'h01BC);
      host.put(8'h06, 16'h03C0);
      wc(4);
      check(left_volume_now, 16'h01BC);
      ticks(4);
      check(left_volume_now, 16'h01C0);
      host.put(8'h05, 16'h0010);
      host.put(8'h06, 16'h0300);
      wc(6);
      check(left_volume_now, 16'h01C0);
      zero_cross_pin <= 1'h1;
      wc(8);
      check(left_volume_now, 16'h0100);
      give_verdict();
   end
endmodule

// ===== test/adcr_host_model.sv
// Host model driving the register strobe bus
module adcr_host_model (
   input  wire        clk,
   input  wire        reg_rvalid,
   input  wire [15:0] reg_rdata,
   output logic       reg_wr,
   output logic       reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   // Idle address and data show the inverse of the last value
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic get(input logic [7:0] a, output logic [15:0] d, output logic ok);
      int n;
      ok = 1'h0;
      d = 16'h0000;
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge clk);
         ok = (reg_rvalid === 1'h1);
         d = reg_rdata;
      end
   endtask
endmodule
